// file: rtl/lfb_pkg.sv
/*
 * Constants for the legacy link byte port: register offsets, field
 * positions, reset values and sizes.
 * Assumes an 8-bit host register port and a framer that strobes one link
 * bit per frame on the same system clock.
 */
// Summary of operation
// - Port runs only in T1 mode
// - Received bits shift in, first bit lands LSB
// - Full byte sets receive-full flag
// - Receive-full with mask enabled drives interrupt low
// - Byte matching either match register sets flag
// - Destuffer deletes zero after five ones
// - Zero after six or more ones kept
// - Transmit byte sent LSB first
// - After eight bits, set transmit-empty flag
// - Unwritten transmit byte is resent unchanged
// - Stuffer inserts zero after five ones, extended superframe only
// - Twelve-frame mode sends frame-sync bits from byte
package lfb_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_RX_BYTE = 8'hc0;
    localparam logic [7:0] ADDR_TX_BYTE = 8'hc1;
    localparam logic [7:0] ADDR_MATCH_ONE = 8'hc2;
    localparam logic [7:0] ADDR_MATCH_TWO = 8'hc3;
    localparam logic [7:0] ADDR_STATUS = 8'hc8;
    localparam logic [7:0] ADDR_MASK = 8'hc9;
    localparam logic [7:0] ADDR_RX_CTRL = 8'hca;
    localparam logic [7:0] ADDR_TX_CTRL = 8'hcb;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_MATCH = 1;
    localparam int BIT_TX_EMPTY = 2;
    localparam int BIT_RX_FULL = 3;
    localparam int BIT_DESTUFF_EN = 3;
    localparam int BIT_STUFF_EN = 5;

    // ****************************************************************
    // Reset values and sizes
    // ****************************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] ONES_MAX = 3'h7;
    localparam int FIFO_DEPTH = 4;

endpackage : lfb_pkg

// file: rtl/lfb_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
module lfb_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
    logic [AW-1:0] wr_q;              // Write pointer
    logic [AW-1:0] rd_q;              // Read pointer
    logic [AW:0] count_q;             // Words held
    logic push;
    logic pop;

    // Honest full and empty
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // ****************************************************************
    // Storage write
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    // ****************************************************************
    // Pointers and count
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : lfb_fifo

// file: rtl/lfb_port.sv
/*
 * Legacy T1 link byte port: receive byte assembly with match and zero
 * destuffing, transmit byte serialiser with zero stuffing, status flags,
 * mask and an active-low interrupt.
 * Assumes the framer strobes rx_bit_valid for each received link or
 * frame-sync bit and tx_bit_req for each outgoing bit slot, all on clk_sys.
 */
module lfb_port #(
    parameter int FIFO_DEPTH = lfb_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic t1_mode,
    input wire logic extended_superframe,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    output logic rx_bit_ready,
    input wire logic tx_bit_req,
    output logic tx_bit,
    output logic tx_bit_valid,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic int_n
);
    // ****************************************************************
    // Registers and internal state
    // ****************************************************************
    logic [7:0] receive_link_byte_q;      // Last completed receive byte
    logic [7:0] transmit_link_byte_q;     // Host transmit byte
    logic [7:0] receive_link_match_one_q; // First match byte
    logic [7:0] receive_link_match_two_q; // Second match byte
    logic [7:0] link_status_flags_q;      // Sticky event flags
    logic [7:0] link_interrupt_mask_q;    // Interrupt enables
    logic [7:0] receive_t1_control_two_q; // Receive control
    logic [7:0] transmit_t1_control_two_q; // Transmit control
    logic [7:0] rx_shift_q;               // Receive assembly
    logic [3:0] rx_count_q;               // Bits assembled
    logic [2:0] rx_ones_q;                // Receive run of ones
    logic [7:0] tx_shift_q;               // Transmit serialiser
    logic [3:0] tx_count_q;               // Bits sent from byte
    logic [2:0] tx_ones_q;                // Transmit run of ones
    logic rx_stall_q;                     // One idle cycle after a byte
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_bit;
    logic rx_take;
    logic rx_drop;
    logic rx_done;
    logic [7:0] rx_next;
    logic tx_stuff;
    logic tx_done;
    logic status_rd;

    // ****************************************************************
    // Receive bit buffer
    // ****************************************************************
    lfb_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(rx_bit_valid && t1_mode),
        .in_ready(rx_bit_ready),
        .in_data(rx_bit),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_bit)
    );

    // Drain stalls for one cycle after each completed byte
    assign fifo_ready = !rx_stall_q;
    assign rx_take = fifo_valid && fifo_ready;

    // Zero after exactly five ones is removed, after six or more kept
    assign rx_drop = receive_t1_control_two_q[lfb_pkg::BIT_DESTUFF_EN]
        && !fifo_bit && (rx_ones_q == lfb_pkg::STUFF_RUN);

    // New bit enters at the top so the first bit ends at bit 0
    assign rx_next = {fifo_bit, rx_shift_q[7:1]};
    assign rx_done = rx_take && !rx_drop
        && (rx_count_q == 4'(lfb_pkg::BYTE_BITS - 1));

    // ****************************************************************
    // Receive run-of-ones counter
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_ones_q <= '0;
        end
        else if (rx_take)
        begin
            if (!fifo_bit)
            begin
                rx_ones_q <= '0;
            end
            else if (rx_ones_q != lfb_pkg::ONES_MAX)
            begin
                rx_ones_q <= rx_ones_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Receive byte assembly
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_shift_q <= lfb_pkg::RESET_BYTE;
            rx_count_q <= '0;
            rx_stall_q <= 1'b0;
            receive_link_byte_q <= lfb_pkg::RESET_BYTE;
        end
        else
        begin
            rx_stall_q <= rx_done;
            if (rx_take && !rx_drop)
            begin
                rx_shift_q <= rx_next;
                rx_count_q <= rx_done ? '0 : rx_count_q + 1'b1;
            end
            if (rx_done)
            begin
                // Overwrites an unread byte
                receive_link_byte_q <= rx_next;
            end
        end
    end

    // ****************************************************************
    // Transmit serialiser
    // ****************************************************************
    // Stuffing applies to the facility link only
    assign tx_stuff = transmit_t1_control_two_q[lfb_pkg::BIT_STUFF_EN]
        && extended_superframe
        && (tx_ones_q == lfb_pkg::STUFF_RUN);
    assign tx_done = tx_bit_req && t1_mode && !tx_stuff
        && (tx_count_q == 4'(lfb_pkg::BYTE_BITS - 1));

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_shift_q <= lfb_pkg::RESET_BYTE;
            tx_count_q <= '0;
            tx_ones_q <= '0;
            tx_bit <= 1'b0;
            tx_bit_valid <= 1'b0;
        end
        else
        begin
            tx_bit_valid <= tx_bit_req && t1_mode;
            if (tx_bit_req && t1_mode)
            begin
                if (tx_stuff)
                begin
                    // Inserted zero, byte position holds
                    tx_bit <= 1'b0;
                    tx_ones_q <= '0;
                end
                else
                begin
                    // Same byte also feeds frame-sync bits
                    tx_bit <= tx_shift_q[0];
                    // Saturate so a long run cannot wrap back to five
                    if (!tx_shift_q[0])
                    begin
                        tx_ones_q <= '0;
                    end
                    else if (tx_ones_q != lfb_pkg::ONES_MAX)
                    begin
                        tx_ones_q <= tx_ones_q + 1'b1;
                    end
                    tx_count_q <= tx_done ? '0 : tx_count_q + 1'b1;
                    // Reload current register, old value if unwritten
                    tx_shift_q <= tx_done ? transmit_link_byte_q
                        : {1'b0, tx_shift_q[7:1]};
                end
            end
        end
    end

    // ****************************************************************
    // Host register writes
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            transmit_link_byte_q <= lfb_pkg::RESET_BYTE;
            receive_link_match_one_q <= lfb_pkg::RESET_BYTE;
            receive_link_match_two_q <= lfb_pkg::RESET_BYTE;
            link_interrupt_mask_q <= lfb_pkg::RESET_BYTE;
            receive_t1_control_two_q <= lfb_pkg::RESET_BYTE;
            transmit_t1_control_two_q <= lfb_pkg::RESET_BYTE;
        end
        else if (bus_wr)
        begin
            case (bus_addr)
                lfb_pkg::ADDR_TX_BYTE: transmit_link_byte_q <= bus_wdata;
                lfb_pkg::ADDR_MATCH_ONE:
                    receive_link_match_one_q <= bus_wdata;
                lfb_pkg::ADDR_MATCH_TWO:
                    receive_link_match_two_q <= bus_wdata;
                lfb_pkg::ADDR_MASK: link_interrupt_mask_q <= bus_wdata;
                lfb_pkg::ADDR_RX_CTRL:
                    receive_t1_control_two_q <= bus_wdata;
                lfb_pkg::ADDR_TX_CTRL:
                    transmit_t1_control_two_q <= bus_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Sticky status flags, clear on read, set wins
    // ****************************************************************
    assign status_rd = bus_rd && (bus_addr == lfb_pkg::ADDR_STATUS);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link_status_flags_q <= lfb_pkg::RESET_BYTE;
        end
        else
        begin
            if (status_rd)
            begin
                link_status_flags_q <= lfb_pkg::RESET_BYTE;
            end
            if (rx_done)
            begin
                link_status_flags_q[lfb_pkg::BIT_RX_FULL] <= 1'b1;
            end
            if (rx_done && ((rx_next == receive_link_match_one_q)
                || (rx_next == receive_link_match_two_q)))
            begin
                link_status_flags_q[lfb_pkg::BIT_MATCH] <= 1'b1;
            end
            if (tx_done)
            begin
                link_status_flags_q[lfb_pkg::BIT_TX_EMPTY] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Read data and interrupt
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_rdata <= lfb_pkg::RESET_BYTE;
            int_n <= 1'b1;
        end
        else
        begin
            // Masked flags pull the interrupt low
            int_n <= ~|(link_status_flags_q & link_interrupt_mask_q);
            if (bus_rd)
            begin
                case (bus_addr)
                    lfb_pkg::ADDR_RX_BYTE: bus_rdata <= receive_link_byte_q;
                    lfb_pkg::ADDR_TX_BYTE: bus_rdata <= transmit_link_byte_q;
                    lfb_pkg::ADDR_MATCH_ONE:
                        bus_rdata <= receive_link_match_one_q;
                    lfb_pkg::ADDR_MATCH_TWO:
                        bus_rdata <= receive_link_match_two_q;
                    lfb_pkg::ADDR_STATUS: bus_rdata <= link_status_flags_q;
                    lfb_pkg::ADDR_MASK: bus_rdata <= link_interrupt_mask_q;
                    lfb_pkg::ADDR_RX_CTRL:
                        bus_rdata <= receive_t1_control_two_q;
                    lfb_pkg::ADDR_TX_CTRL:
                        bus_rdata <= transmit_t1_control_two_q;
                    default: bus_rdata <= lfb_pkg::RESET_BYTE;
                endcase
            end
        end
    end

endmodule : lfb_port

// file: tb/lfb_port_chk.sv
/*
 * Checker for lfb_port: bit slot timing, stuffing, read data, interrupt.
 * Assumes it sees only the top module's ports; bound at the foot.
 */
module lfb_port_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic t1_mode,
    input wire logic extended_superframe,
    input wire logic rx_bit_valid,
    input wire logic tx_bit_req,
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    input wire logic [7:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic int_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stuff_q; // Shadow of the stuffing enable
    logic mask_q; // Shadow of the transmit-empty mask
    logic [2:0] ones_q; // Ones sent in a row
    logic [2:0] bits_q; // Data bits sent of this byte
    logic stuffed; // This slot must carry an inserted zero
    assign stuffed = stuff_q && extended_superframe &&
        ones_q == lfb_pkg::STUFF_RUN;
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // Shadows of the host writes that steer the transmit side
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stuff_q <= 1'b0;
            mask_q <= 1'b0;
        end
        else if (bus_wr && bus_addr == lfb_pkg::ADDR_TX_CTRL)
            stuff_q <= bus_wdata[lfb_pkg::BIT_STUFF_EN];
        else if (bus_wr && bus_addr == lfb_pkg::ADDR_MASK)
            mask_q <= bus_wdata[lfb_pkg::BIT_TX_EMPTY];
    end
    // Run of ones and data position; inserted zeros do not count
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ones_q <= 3'h0;
            bits_q <= 3'h0;
        end
        else if (tx_bit_valid)
        begin
            ones_q <= !tx_bit ? 3'h0 :
                (ones_q == lfb_pkg::ONES_MAX) ? ones_q : ones_q + 3'h1;
            if (!stuffed)
                bits_q <= bits_q + 3'h1;
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_quiet;
        !rx_bit_valid && !tx_bit_req;
    endsequence
    sequence s_mask_off;
        bus_wr && bus_addr == lfb_pkg::ADDR_MASK && bus_wdata == 8'h00
        ##1 !(bus_wr && bus_addr == lfb_pkg::ADDR_MASK);
    endsequence
    a_tx_slot_answer: assert property (
        tx_bit_req && t1_mode |=> tx_bit_valid)
        else $error("bit slot not answered");
    a_tx_slot_cause: assert property (
        tx_bit_valid |-> $past(tx_bit_req && t1_mode))
        else $error("bit slot without request in T1 mode");
    a_tx_bit_hold: assert property (
        $changed(tx_bit) |-> tx_bit_valid)
        else $error("outgoing bit changed outside a slot");
    a_stuff_zero_insert: assert property (
        tx_bit_valid && stuffed |-> !tx_bit)
        else $error("no zero after five ones");
    a_tx_empty_int: assert property (
        tx_bit_valid && !stuffed && bits_q == 3'h7 && mask_q |=> !int_n)
        else $error("no interrupt after eighth bit");
    a_read_clears_int: assert property (
        s_quiet [*8] ##1 (!rx_bit_valid && !tx_bit_req && bus_rd &&
        bus_addr == lfb_pkg::ADDR_STATUS) ##1 s_quiet [*2] |-> int_n)
        else $error("interrupt stays after status read");
    a_mask_off_int: assert property (
        s_mask_off |=> int_n)
        else $error("interrupt low with all masked");
    a_rdata_hold: assert property (
        !bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without a read");
endmodule : lfb_port_chk

bind lfb_port lfb_port_chk lfb_port_chk_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .t1_mode(t1_mode),
    .extended_superframe(extended_superframe),
    .rx_bit_valid(rx_bit_valid), .tx_bit_req(tx_bit_req),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .int_n(int_n));

// file: tb/lfb_framer_model.sv
/*
 * Framer-side partner: offers received link bits, asks for bit slots.
 * Assumes its tasks are entered just after a rising edge of clk_sys.
 */
module lfb_framer_model (
    input wire logic clk_sys,
    output logic rx_bit_valid,
    output logic rx_bit,
    input wire logic rx_bit_ready,
    output logic tx_bit_req,
    input wire logic tx_bit,
    input wire logic tx_bit_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines at time zero
    initial
    begin
        rx_bit_valid = 1'b0;
        rx_bit = 1'b0;
        tx_bit_req = 1'b0;
    end
    // Offer n bits, bit 0 first; each held until ready, gap 0 is dense
    task send(input logic [15:0] bits, input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            if (gap > 0 && i > 0)
            begin
                rx_bit_valid <= 1'b0;
                rx_bit <= ~bits[i-1]; // Released line shows no stale bit
            end
            repeat (gap) @(posedge clk_sys);
            rx_bit_valid <= 1'b1;
            rx_bit <= bits[i];
            do @(posedge clk_sys); while (rx_bit_ready !== 1'b1);
        end
        rx_bit_valid <= 1'b0;
        rx_bit <= ~bits[n-1];
    endtask : send
    // Ask for n slots; a slot left unanswered reads as unknown
    task pull(output logic [15:0] bits, input int n);
        bits = 'x;
        for (int i = 0; i < n; i++)
        begin
            tx_bit_req <= 1'b1;
            @(posedge clk_sys);
            tx_bit_req <= 1'b0;
            @(negedge clk_sys);
            if (tx_bit_valid === 1'b1)
                bits[i] = tx_bit;
            @(posedge clk_sys);
        end
    endtask : pull
endmodule : lfb_framer_model

// file: tb/test_lfb_port.sv
/*
 * Self-checking bench for lfb_port with the framer partner model.
 * Assumes the checker is bound from its own file.
 */
module test_lfb_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset_n, t1_mode, extended_superframe;
    logic rx_bit_valid, rx_bit, rx_bit_ready, tx_bit_req, tx_bit;
    logic tx_bit_valid, bus_wr, bus_rd, int_n;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [15:0] raw; // Raw bits taken from the outgoing stream
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    lfb_port lfb_port_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .t1_mode(t1_mode), .extended_superframe(extended_superframe),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_bit_ready(rx_bit_ready), .tx_bit_req(tx_bit_req),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .int_n(int_n));
    lfb_framer_model lfb_framer_model_i (.clk_sys(clk_sys),
        .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
        .rx_bit_ready(rx_bit_ready), .tx_bit_req(tx_bit_req),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid));
    // 200 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            results;
        end
    end
    task results;
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    // Read and compare one register
    task rdc(input logic [7:0] a, input logic [7:0] e);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk(bus_rdata, e);
        @(posedge clk_sys);
    endtask : rdc
    // Wait a bounded time for the interrupt to go low
    task wait_int;
        for (int n = 0; n < 40 && int_n !== 1'b0; n++)
            @(posedge clk_sys);
        chk({7'h00, int_n}, 8'h00);
    endtask : wait_int
    task t_regs;
        logic [7:0] a;
        rdc(lfb_pkg::ADDR_STATUS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            a = lfb_pkg::ADDR_RX_BYTE + 8'(i);
            rdc(a, 8'h00);
            wr(a, 8'h5a + 8'(i));
            rdc(a, (i == 0) ? 8'h00 : 8'h5a + 8'(i));
        end
        rdc(8'h00, 8'h00);
        chk({6'h00, rx_bit_ready, int_n}, 8'h03);
    endtask : t_regs
    task t_rx;
        logic [7:0] b [3];
        b = '{8'h5a, 8'hc3, 8'h3c};
        wr(lfb_pkg::ADDR_MATCH_ONE, 8'hc3);
        wr(lfb_pkg::ADDR_MATCH_TWO, 8'h3c);
        wr(lfb_pkg::ADDR_MASK, 8'h0a);
        for (int i = 0; i < 3; i++)
        begin
            lfb_framer_model_i.send({8'h00, b[i]}, 8, i);
            wait_int;
            rdc(lfb_pkg::ADDR_RX_BYTE, b[i]);
            rdc(lfb_pkg::ADDR_STATUS, (i == 0) ? 8'h08 : 8'h0a);
            rdc(lfb_pkg::ADDR_STATUS, 8'h00);
        end
        lfb_framer_model_i.send(16'hc35a, 16, 0);
        repeat (4) @(posedge clk_sys);
        rdc(lfb_pkg::ADDR_RX_BYTE, 8'hc3);
        wr(lfb_pkg::ADDR_MASK, 8'h00);
        @(negedge clk_sys);
        chk({7'h00, int_n}, 8'h01);
        @(posedge clk_sys);
        rdc(lfb_pkg::ADDR_STATUS, 8'h0a);
    endtask : t_rx
    task t_destuff;
        wr(lfb_pkg::ADDR_RX_CTRL, 8'h08);
        wr(lfb_pkg::ADDR_MASK, 8'h08);
        lfb_framer_model_i.send(16'h00be, 9, 0);
        wait_int;
        rdc(lfb_pkg::ADDR_RX_BYTE, 8'h7e);
        rdc(lfb_pkg::ADDR_STATUS, 8'h08);
        lfb_framer_model_i.send(16'h00bf, 8, 1);
        wait_int;
        rdc(lfb_pkg::ADDR_RX_BYTE, 8'hbf);
        rdc(lfb_pkg::ADDR_STATUS, 8'h08);
    endtask : t_destuff
    task t_mode_off;
        t1_mode <= 1'b0;
        lfb_framer_model_i.send(16'h00ff, 8, 0);
        lfb_framer_model_i.pull(raw, 2);
        rdc(lfb_pkg::ADDR_STATUS, 8'h00);
        t1_mode <= 1'b1;
        lfb_framer_model_i.send(16'h0081, 8, 0);
        wait_int;
        rdc(lfb_pkg::ADDR_RX_BYTE, 8'h81);
        rdc(lfb_pkg::ADDR_STATUS, 8'h08);
    endtask : t_mode_off
    task t_tx;
        wr(lfb_pkg::ADDR_MASK, 8'h04);
        wr(lfb_pkg::ADDR_TX_CTRL, 8'h20);
        wr(lfb_pkg::ADDR_TX_BYTE, 8'hff);
        lfb_framer_model_i.pull(raw, 8);
        chk(raw[7:0], 8'h00);
        rdc(lfb_pkg::ADDR_STATUS, 8'h04);
        lfb_framer_model_i.pull(raw, 9);
        chk(raw[7:0], 8'hdf);
        chk({7'h00, raw[8]}, 8'h01);
        wr(lfb_pkg::ADDR_TX_CTRL, 8'h00);
        wr(lfb_pkg::ADDR_TX_BYTE, 8'h3c);
        lfb_framer_model_i.pull(raw, 8);
        chk(raw[7:0], 8'hff);
        lfb_framer_model_i.pull(raw, 8);
        chk(raw[7:0], 8'h3c);
        extended_superframe <= 1'b0;
        wr(lfb_pkg::ADDR_TX_CTRL, 8'h20);
        wr(lfb_pkg::ADDR_TX_BYTE, 8'hff);
        lfb_framer_model_i.pull(raw, 8);
        chk(raw[7:0], 8'h3c);
        lfb_framer_model_i.pull(raw, 8);
        chk(raw[7:0], 8'hff);
    endtask : t_tx
    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        t1_mode = 1'b1;
        extended_superframe = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        t_regs;
        t_rx;
        t_destuff;
        t_mode_off;
        t_tx;
        results;
    end
endmodule : test_lfb_port
